// ===== shared/rbb_pkg.sv
package rbb_pkg;
  // Bus widths; the card drives the low sixteen address lines only.
  localparam int RBB_ADDR_W = 16;
  localparam int RBB_DATA_W = 16;
  localparam int RBB_BYTE_W = 8;
  localparam int RBB_REFRESH_CYCLE_N_W = 7;
  // Memory-mapped I/O window: upper address byte that selects I/O.
  localparam logic [7:0] RBB_IO_WINDOW_HI = 8'hFF;
  // The module's I/O port number and its ROM/shadow RAM page.
  localparam logic [7:0] RBB_IO_PORT = 8'h40;
  localparam logic [7:0] RBB_MEM_PAGE_HI = 8'h00;
  // Reset value of the paging signal: ROM at the bottom of memory.
  localparam logic RBB_PAGE_RESET = 1'b0;
  // Wait states the module inserts and the length of its NMI pulse.
  localparam logic [1:0] RBB_WAIT_CYCLES = 2'h1;
  localparam logic [2:0] RBB_NMI_LOW_CYCLES = 3'h4;

  // Commands accepted by the processor card's user port.
  typedef enum logic [2:0] {
    RBB_READ, RBB_WRITE, RBB_FETCH, RBB_IO_READ, RBB_IO_WRITE,
    RBB_HALT, RBB_PAGE_ROM, RBB_PAGE_RAM
  } rbb_kind_t;
endpackage

// ===== shared/rbb_if.sv
`timescale 1ns/1ps
interface rbb_if (
  input wire logic bus_clk,
  input wire logic bus_reset_n
);
  import rbb_pkg::*;
  // Processor card drives.
  logic [RBB_ADDR_W-1:0] addr_o;
  logic                  addr_oe_n;
  logic [RBB_BYTE_W-1:0] cpu_data_o;
  logic                  cpu_data_oe_n;
  logic                  memory_cycle_n_o, io_cycle_n_o, rd_o, wr_o, ctl_oe_n;
  logic                  opcode_fetch_cycle_n, refresh_cycle_n;
  logic                  bus_released_n, halt_n, page;
  logic                  tx, tx2, dma_ack_chain_out_n;
  // Module drives.
  logic [RBB_BYTE_W-1:0] mod_data_o;
  logic                  mod_data_oe_n, int_oe_n, wait_oe_n;
  logic                  bus_takeover_req_n, nmi_n, rx, rx2, irq_chain_out;
  // Driven by the bench: the chain input of the single slot.
  logic                  irq_chain_in;
  // Resolved backplane wires.
  logic [23:0]           addr;
  logic [RBB_DATA_W-1:0] data;
  logic                  memory_cycle_n, io_cycle_n, rd_n, wr_n;
  logic                  int_n, wait_n, dma_ack_chain_in_n;

  // Floating address lines read as pulled down, control lines pulled up.
  assign addr = {8'h00, addr_oe_n ? 16'h0000 : addr_o};
  assign data = !cpu_data_oe_n ? {8'h00, cpu_data_o} :
                !mod_data_oe_n ? {8'h00, mod_data_o} : 16'h0000;
  assign memory_cycle_n = ctl_oe_n | memory_cycle_n_o;
  assign io_cycle_n = ctl_oe_n | io_cycle_n_o;
  assign rd_n = ctl_oe_n | rd_o;
  assign wr_n = ctl_oe_n | wr_o;
  assign int_n = int_oe_n;
  assign wait_n = wait_oe_n;
  assign dma_ack_chain_in_n = dma_ack_chain_out_n;

  modport cpu_end (
    input  bus_clk, bus_reset_n, data, int_n, wait_n,
           bus_takeover_req_n, nmi_n, rx, rx2,
    output addr_o, addr_oe_n, cpu_data_o, cpu_data_oe_n, memory_cycle_n_o, io_cycle_n_o,
           rd_o, wr_o, ctl_oe_n, opcode_fetch_cycle_n, refresh_cycle_n,
           bus_released_n, halt_n, page, tx, tx2, dma_ack_chain_out_n
  );
  modport mod_end (
    input  bus_clk, bus_reset_n, addr, data, memory_cycle_n, io_cycle_n,
           rd_n, wr_n, refresh_cycle_n, page, tx, tx2, irq_chain_in,
           dma_ack_chain_in_n, bus_released_n,
    output mod_data_o, mod_data_oe_n, int_oe_n, wait_oe_n,
           bus_takeover_req_n, nmi_n, rx, rx2, irq_chain_out
  );
endinterface

// ===== hdl/rbb_mod_end.sv
`timescale 1ns/1ps
module rbb_mod_end (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          irq_req,
  input  wire logic                          takeover_req,
  input  wire logic                          nmi_req,
  output logic                               granted,
  output logic                               io_valid,
  output logic [rbb_pkg::RBB_BYTE_W-1:0]     io_data,
  input  wire logic                          rx_in,
  input  wire logic                          rx2_in,
  output logic                               tx_out,
  output logic                               tx2_out,
  rbb_if.mod_end                             bus
);
  import rbb_pkg::*;

  logic                  bus_rst;
  logic [3:0]            lv_s1, lv_s2;
  logic [2:0]            nmi_s;
  logic                  nmi_tog;
  logic [2:0]            nmi_cnt;
  logic                  in_cyc;
  logic [1:0]            wcnt;
  logic [RBB_BYTE_W-1:0] ram [0:255];
  logic [RBB_BYTE_W-1:0] io_q;
  logic                  io_tog;
  logic [2:0]            io_s;
  logic [3:0]            st_s1, st_s2;
  logic                  hit_mem, hit_io, is_rd, rom_sel;

  // ROM contents are a fixed pattern derived from the address.
  function automatic logic [RBB_BYTE_W-1:0] rom_byte(input logic [7:0] a);
    rom_byte = a ^ 8'hA5;
  endfunction

  assign bus_rst = !bus.bus_reset_n; // RL15
  // Respond only to qualified memory or I/O cycles, never to refresh.
  assign is_rd = !bus.rd_n;
  assign hit_mem = !bus.memory_cycle_n && bus.refresh_cycle_n &&
                   (is_rd || !bus.wr_n) &&
                   bus.addr[15:8] == RBB_MEM_PAGE_HI; // RL24
  assign hit_io = !bus.io_cycle_n && (is_rd || !bus.wr_n) &&
                  bus.addr[7:0] == RBB_IO_PORT; // RL24
  assign rom_sel = !bus.page; // RL11 RL12

  // User levels cross into the bus domain.
  always_ff @(posedge bus.bus_clk) begin
    lv_s1 <= {rx2_in, rx_in, takeover_req, irq_req};
    lv_s2 <= lv_s1;
  end

  // Open-drain interrupt, takeover request, serial and priority chain.
  always_ff @(posedge bus.bus_clk) begin
    if (bus_rst) begin
      bus.int_oe_n <= 1'b1;
      bus.bus_takeover_req_n <= 1'b1;
      bus.rx <= 1'b1;
      bus.rx2 <= 1'b1;
    end else begin
      bus.int_oe_n <= !lv_s2[0]; // RL6
      bus.bus_takeover_req_n <= !lv_s2[1]; // RL3
      bus.rx <= lv_s2[2]; // RL19
      bus.rx2 <= lv_s2[3];
    end
  end
  assign bus.irq_chain_out = bus.irq_chain_in && !lv_s2[0]; // RL22 RL23

  // NMI request crosses as a toggle and becomes a fixed low pulse.
  always_ff @(posedge clk) begin
    if (reset) nmi_tog <= 1'b0;
    else if (nmi_req) nmi_tog <= !nmi_tog;
  end
  always_ff @(posedge bus.bus_clk) begin
    nmi_s <= {nmi_s[1:0], nmi_tog};
    if (bus_rst) begin
      nmi_cnt <= 3'h0;
      bus.nmi_n <= 1'b1;
    end else if (nmi_s[2] != nmi_s[1]) begin
      nmi_cnt <= RBB_NMI_LOW_CYCLES;
      bus.nmi_n <= 1'b0;
    end else if (nmi_cnt != 3'h0) begin
      nmi_cnt <= nmi_cnt - 3'h1;
      bus.nmi_n <= (nmi_cnt == 3'h1);
    end
  end

  // Access engine: waits, then answers reads or takes writes once.
  always_ff @(posedge bus.bus_clk) begin
    if (bus_rst) begin
      in_cyc <= 1'b0;
      wcnt <= 2'h0;
      bus.wait_oe_n <= 1'b1;
      bus.mod_data_oe_n <= 1'b1;
      bus.mod_data_o <= 8'h00;
      io_q <= 8'h00;
      io_tog <= 1'b0;
    end else if (!(hit_mem || hit_io)) begin
      in_cyc <= 1'b0;
      bus.wait_oe_n <= 1'b1;
      bus.mod_data_oe_n <= 1'b1; // RL2
    end else if (!in_cyc) begin
      in_cyc <= 1'b1;
      wcnt <= RBB_WAIT_CYCLES;
      bus.wait_oe_n <= (RBB_WAIT_CYCLES == 2'h0); // RL17
    end else if (wcnt > 2'h1) begin
      wcnt <= wcnt - 2'h1;
    end else if (wcnt == 2'h1) begin
      // Wait rises on the edge that drives read data, so both meet.
      wcnt <= 2'h0;
      bus.wait_oe_n <= 1'b1;
      bus.mod_data_oe_n <= !is_rd;
      if (hit_io) bus.mod_data_o <= io_q;
      else if (rom_sel) bus.mod_data_o <= rom_byte(bus.addr[7:0]);
      else bus.mod_data_o <= ram[bus.addr[7:0]];
    end else if (bus.mod_data_oe_n && hit_io && wcnt == 2'h0) begin
      io_q <= bus.data[7:0];
      io_tog <= !io_tog;
      wcnt <= 2'h3;
    end
  end

  // Shadow RAM takes writes only while the page signal selects it.
  always_ff @(posedge bus.bus_clk) begin
    if (in_cyc && wcnt == 2'h0 && hit_mem && !bus.wr_n && !rom_sel)
      ram[bus.addr[7:0]] <= bus.data[7:0]; // RL11
  end

  // I/O writes and bus levels cross back to the user side.
  always_ff @(posedge clk) begin
    io_s <= {io_s[1:0], io_tog};
    st_s1 <= {bus.tx2, bus.tx, !bus.dma_ack_chain_in_n, 1'b0};
    st_s2 <= st_s1;
    if (reset) begin
      io_valid <= 1'b0;
      io_data <= 8'h00;
    end else begin
      io_valid <= io_s[2] != io_s[1];
      if (io_s[2] != io_s[1]) io_data <= io_q;
    end
  end
  assign granted = st_s2[1]; // RL20
  assign tx_out = st_s2[2];
  assign tx2_out = st_s2[3];
endmodule

// ===== hdl/rbb_cpu_end.sv
`timescale 1ns/1ps
// Operation
// RL1: Card drives low sixteen address lines, tristate.
// RL2: Data lines bidirectional tristate, low byte used.
// RL3: Module pulls takeover request low for ownership.
// RL4: Released indication only after all lines float.
// RL5: Stopped indication held until an interrupt.
// RL6: Interrupt line pulled up, modules pull low.
// RL7: I/O window addresses use the I/O line.
// RL8: Opcode-fetch line only for its own family.
// RL9: Memory cycle line only with valid address.
// RL10: NMI taken on its falling edge.
// RL11: Paging low selects ROM, high shadow RAM.
// RL12: ROM at address zero after reset.
// RL13: Read strobe low to take data.
// RL14: Write strobe low to deliver data.
// RL15: Bus reset is active low everywhere.
// RL16: Refresh line low during refresh cycles.
// RL17: Wait line held stretches the cycle.
// RL18: Bus clock synchronises the processor.
// RL19: Serial out and in lines, two pairs.
// RL20: DMA chain input means buses released.
// RL21: DMA chain output shows bus given up.
// RL22: High chain input means no higher interrupt.
// RL23: Chain output high only if idle upstream.
// RL24: Modules answer only qualified cycles.
module rbb_cpu_end (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire rbb_pkg::rbb_kind_t            req_kind,
  input  wire logic [rbb_pkg::RBB_ADDR_W-1:0] req_addr,
  input  wire logic [rbb_pkg::RBB_BYTE_W-1:0] req_wdata,
  output logic                               rsp_valid,
  output logic [rbb_pkg::RBB_BYTE_W-1:0]     rsp_rdata,
  output logic                               halted,
  output logic                               released,
  output logic                               int_pending,
  output logic                               page_ram,
  output logic                               nmi_seen,
  input  wire logic                          tx_in,
  input  wire logic                          tx2_in,
  output logic                               rx_out,
  output logic                               rx2_out,
  rbb_if.cpu_end                             bus
);
  import rbb_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_STROBE, ST_SAMPLE, ST_REFRESH_CYCLE_N, ST_REFRESH_CYCLE_N_END,
    ST_FLOAT, ST_RELEASED, ST_HALTED
  } rbb_state_t;

  // User side, on clk.
  rbb_kind_t             hold_kind;
  logic [RBB_ADDR_W-1:0] hold_addr;
  logic [RBB_BYTE_W-1:0] hold_wdata;
  logic                  req_tog, busy;
  logic [2:0]            ack_s, nmi_s;
  logic [5:0]            st_s1, st_s2;
  // Bus side, on the bus clock.
  rbb_state_t            state;
  logic                  bus_rst;
  logic [1:0]            rq_s;
  logic                  rq_seen, ack_tog, nmi_tog, nmi_prev, nmi_fall;
  logic [1:0]            tx_s1, tx_s2;
  logic [RBB_BYTE_W-1:0] rdata;
  logic [RBB_REFRESH_CYCLE_N_W-1:0] refresh_cycle_n_ctr;
  logic                  is_write, is_io, is_fetch;

  // Kind decoding used by the bus sequencer.
  function automatic logic kind_writes(input rbb_kind_t k);
    kind_writes = (k == RBB_WRITE) || (k == RBB_IO_WRITE);
  endfunction
  function automatic logic kind_io(input rbb_kind_t k,
                                   input logic [RBB_ADDR_W-1:0] a);
    kind_io = (k == RBB_IO_READ) || (k == RBB_IO_WRITE) ||
              (a[15:8] == RBB_IO_WINDOW_HI);
  endfunction

  // Command capture; fields stay stable until the answer returns.
  assign req_ready = !busy;
  always_ff @(posedge clk) begin
    if (reset) begin
      req_tog <= 1'b0;
      busy <= 1'b0;
      hold_kind <= RBB_READ;
      hold_addr <= 16'h0000;
      hold_wdata <= 8'h00;
    end else if (req_valid && !busy) begin
      req_tog <= !req_tog;
      busy <= 1'b1;
      hold_kind <= req_kind;
      hold_addr <= req_addr;
      hold_wdata <= req_wdata;
    end else if (ack_s[2] != ack_s[1]) begin
      busy <= 1'b0;
    end
  end

  // Answers, NMI events and status levels cross into clk.
  always_ff @(posedge clk) begin
    ack_s <= {ack_s[1:0], ack_tog};
    nmi_s <= {nmi_s[1:0], nmi_tog};
    st_s1 <= {bus.rx2, bus.rx, bus.page, !bus.int_n,
              !bus.bus_released_n, !bus.halt_n};
    st_s2 <= st_s1;
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      nmi_seen <= 1'b0;
    end else begin
      rsp_valid <= ack_s[2] != ack_s[1];
      nmi_seen <= nmi_s[2] != nmi_s[1];
      if (ack_s[2] != ack_s[1]) rsp_rdata <= rdata;
    end
  end
  assign halted = st_s2[0];
  assign released = st_s2[1];
  assign int_pending = st_s2[2];
  assign page_ram = st_s2[3];
  assign rx_out = st_s2[4];
  assign rx2_out = st_s2[5];

  // The bus reset pin resets the bus-side state and pins; the rq_s, tx_s1 and tx_s2 synchronisers are not reset.
  assign bus_rst = !bus.bus_reset_n; // RL15 RL18
  assign is_write = kind_writes(hold_kind);
  assign is_io = kind_io(hold_kind, hold_addr);
  assign is_fetch = hold_kind == RBB_FETCH;

  // Command toggle and serial outputs cross into the bus domain.
  always_ff @(posedge bus.bus_clk) begin
    rq_s <= {rq_s[0], req_tog};
    tx_s1 <= {tx2_in, tx_in};
    tx_s2 <= tx_s1;
  end
  always_ff @(posedge bus.bus_clk) begin
    if (bus_rst) begin
      bus.tx <= 1'b1;
      bus.tx2 <= 1'b1;
    end else begin
      bus.tx <= tx_s2[0]; // RL19
      bus.tx2 <= tx_s2[1];
    end
  end

  // NMI is edge triggered; each falling edge is reported once.
  assign nmi_fall = nmi_prev && !bus.nmi_n;
  always_ff @(posedge bus.bus_clk) begin
    if (bus_rst) begin
      nmi_prev <= 1'b1;
      nmi_tog <= 1'b0;
    end else begin
      nmi_prev <= bus.nmi_n;
      if (nmi_fall) nmi_tog <= !nmi_tog; // RL10
    end
  end

  // Bus cycle sequencer and the pins it owns.
  always_ff @(posedge bus.bus_clk) begin
    if (bus_rst) begin
      state <= ST_IDLE;
      rq_seen <= 1'b0;
      ack_tog <= 1'b0;
      rdata <= 8'h00;
      refresh_cycle_n_ctr <= 7'h00;
      bus.addr_o <= 16'h0000;
      bus.addr_oe_n <= 1'b1;
      bus.cpu_data_o <= 8'h00;
      bus.cpu_data_oe_n <= 1'b1;
      bus.ctl_oe_n <= 1'b0;
      bus.memory_cycle_n_o <= 1'b1;
      bus.io_cycle_n_o <= 1'b1;
      bus.rd_o <= 1'b1;
      bus.wr_o <= 1'b1;
      bus.opcode_fetch_cycle_n <= 1'b1;
      bus.refresh_cycle_n <= 1'b1;
      bus.bus_released_n <= 1'b1;
      bus.halt_n <= 1'b1;
      bus.page <= RBB_PAGE_RESET; // RL12
    end else begin
      case (state)
        ST_IDLE: begin
          if (!bus.bus_takeover_req_n) begin
            state <= ST_FLOAT;
            bus.addr_oe_n <= 1'b1;
            bus.cpu_data_oe_n <= 1'b1;
            bus.ctl_oe_n <= 1'b1;
          end else if (rq_s[1] != rq_seen) begin
            rq_seen <= rq_s[1];
            case (hold_kind)
              RBB_HALT: begin
                state <= ST_HALTED;
                bus.halt_n <= 1'b0; // RL5
              end
              RBB_PAGE_ROM, RBB_PAGE_RAM: begin
                bus.page <= hold_kind == RBB_PAGE_RAM; // RL11 RL12
                ack_tog <= !ack_tog;
              end
              default: begin
                state <= ST_ADDR;
                bus.addr_o <= hold_addr; // RL1
                bus.addr_oe_n <= 1'b0;
                bus.opcode_fetch_cycle_n <= !is_fetch; // RL8
              end
            endcase
          end
        end
        ST_ADDR: begin
          state <= ST_STROBE;
          bus.memory_cycle_n_o <= is_io; // RL7 RL9
          bus.io_cycle_n_o <= !is_io; // RL7
          bus.rd_o <= is_write; // RL13
          bus.wr_o <= !is_write; // RL14
          bus.cpu_data_o <= hold_wdata;
          bus.cpu_data_oe_n <= !is_write; // RL2
        end
        ST_STROBE: state <= ST_SAMPLE;
        ST_SAMPLE: begin
          if (bus.wait_n) begin // RL17
            rdata <= bus.data[7:0];
            bus.memory_cycle_n_o <= 1'b1;
            bus.io_cycle_n_o <= 1'b1;
            bus.rd_o <= 1'b1;
            bus.wr_o <= 1'b1;
            bus.cpu_data_oe_n <= 1'b1;
            bus.opcode_fetch_cycle_n <= 1'b1;
            if (is_fetch) begin
              state <= ST_REFRESH_CYCLE_N;
              bus.addr_o <= {9'h000, refresh_cycle_n_ctr};
              bus.refresh_cycle_n <= 1'b0; // RL16
            end else begin
              state <= ST_IDLE;
              bus.addr_oe_n <= 1'b1;
              ack_tog <= !ack_tog;
            end
          end
        end
        ST_REFRESH_CYCLE_N: begin
          state <= ST_REFRESH_CYCLE_N_END;
          bus.memory_cycle_n_o <= 1'b0; // RL16
        end
        ST_REFRESH_CYCLE_N_END: begin
          state <= ST_IDLE;
          bus.memory_cycle_n_o <= 1'b1;
          bus.refresh_cycle_n <= 1'b1;
          bus.addr_oe_n <= 1'b1;
          refresh_cycle_n_ctr <= refresh_cycle_n_ctr + 7'h01;
          ack_tog <= !ack_tog;
        end
        ST_FLOAT: begin
          state <= ST_RELEASED;
          bus.bus_released_n <= 1'b0; // RL4
        end
        ST_RELEASED: begin
          if (bus.bus_takeover_req_n) begin
            state <= ST_IDLE;
            bus.bus_released_n <= 1'b1;
            bus.ctl_oe_n <= 1'b0;
          end
        end
        ST_HALTED: begin
          if (!bus.int_n || nmi_fall) begin // RL5
            state <= ST_IDLE;
            bus.halt_n <= 1'b1;
            ack_tog <= !ack_tog;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // The DMA chain output follows the released indication.
  assign bus.dma_ack_chain_out_n = bus.bus_released_n; // RL21
endmodule

// ===== dv/rbb_checker.sv
`timescale 1ns/1ps
// Watches the backplane wires.
module rbb_checker (
  input wire logic       bus_clk,
  input wire logic       bus_reset_n,
  input wire logic [7:0] addr_hi,
  input wire logic       addr_oe_n,
  input wire logic       cpu_data_oe_n,
  input wire logic       ctl_oe_n,
  input wire logic       memory_cycle_n,
  input wire logic       io_cycle_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       refresh_cycle_n,
  input wire logic       bus_released_n,
  input wire logic       bus_takeover_req_n,
  input wire logic       dma_ack_chain_out_n,
  input wire logic       halt_n,
  input wire logic       int_n,
  input wire logic       nmi_n,
  input wire logic       wait_n,
  input wire logic       page,
  input wire logic       irq_chain_in,
  input wire logic       irq_chain_out
);
  import rbb_pkg::*;
  // Checks run on the bus clock, idle in bus reset.
  default clocking bcb @(posedge bus_clk);
  endclocking
  default disable iff (!bus_reset_n);

  // Bus release only on demand, with all lines floating.
  a_release_floats: assert property (
    !bus_released_n |-> addr_oe_n && cpu_data_oe_n && ctl_oe_n)
    else $error("bus released while card still drives");
  a_release_cause: assert property (
    $fell(bus_released_n) |-> $past(bus_takeover_req_n) == 1'h0)
    else $error("bus released without a takeover request");
  a_dma_chain_out: assert property (
    dma_ack_chain_out_n == bus_released_n)
    else $error("dma chain output differs from release state");
  // Memory cycles need a driven address outside the I/O window.
  a_mem_addr_valid: assert property (
    !memory_cycle_n |-> !addr_oe_n)
    else $error("memory cycle without a driven address");
  a_mem_not_window: assert property (
    !memory_cycle_n |-> addr_hi != RBB_IO_WINDOW_HI)
    else $error("memory cycle inside the I/O window");
  a_io_not_mem: assert property (
    !io_cycle_n |-> memory_cycle_n && !addr_oe_n)
    else $error("I/O cycle overlaps a memory cycle");
  a_strobe_qualified: assert property (
    (!rd_n || !wr_n) |-> (rd_n != wr_n) && !(memory_cycle_n && io_cycle_n))
    else $error("strobe without a single qualified cycle");
  a_refresh_quiet: assert property (
    !refresh_cycle_n |-> rd_n && wr_n && io_cycle_n)
    else $error("strobe active in a refresh cycle");
  // Wait, halt, paging and the interrupt chain.
  a_wait_stretch: assert property (
    (!rd_n && !wait_n) |=> !rd_n)
    else $error("read ended while wait was asserted");
  a_halt_holds: assert property (
    (!halt_n && int_n && nmi_n) |=> !halt_n)
    else $error("halt left without an interrupt");
  a_page_reset: assert property (
    $rose(bus_reset_n) |-> !page)
    else $error("paging not ROM after reset");
  a_irq_chain_out: assert property (
    irq_chain_out |-> irq_chain_in)
    else $error("interrupt chain output high with input low");
endmodule

// ===== dv/retro_backplane_bus_tb_top.sv
`timescale 1ns/1ps
module retro_backplane_bus_tb_top;
  import rbb_pkg::*;
  logic                  clk, reset, bus_clk, bus_reset_n;
  logic                  req_valid, req_ready, rsp_valid;
  rbb_kind_t             req_kind;
  logic [RBB_ADDR_W-1:0] req_addr;
  logic [RBB_BYTE_W-1:0] req_wdata, rsp_rdata, io_data, rd;
  logic                  halted, released, int_pending, page_ram, nmi_seen;
  logic                  tx_in, tx2_in, rx_out, rx2_out, rx_in, rx2_in;
  logic                  tx_out, tx2_out, irq_req, takeover_req, nmi_req;
  logic                  granted, io_valid, saw_refresh_cycle_n, saw_fetch;
  int                    miscompares, n_compared, rsp_cnt, io_cnt, nmi_cnt;

  // Core clock 4 ns; bus clock 12 ns, offset in phase.
  always #2 clk = ~clk;
  initial begin
    bus_clk = 1'h0;
    #1.3;
    forever #6 bus_clk = ~bus_clk;
  end

  rbb_if rbb_if_inst (.bus_clk(bus_clk), .bus_reset_n(bus_reset_n));
  rbb_cpu_end rbb_cpu_end_inst (.clk(clk), .reset(reset),
    .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .halted(halted), .released(released),
    .int_pending(int_pending), .page_ram(page_ram), .nmi_seen(nmi_seen),
    .tx_in(tx_in), .tx2_in(tx2_in), .rx_out(rx_out), .rx2_out(rx2_out),
    .bus(rbb_if_inst));
  rbb_mod_end rbb_mod_end_inst (.clk(clk), .reset(reset),
    .irq_req(irq_req), .takeover_req(takeover_req), .nmi_req(nmi_req),
    .granted(granted), .io_valid(io_valid), .io_data(io_data),
    .rx_in(rx_in), .rx2_in(rx2_in), .tx_out(tx_out), .tx2_out(tx2_out),
    .bus(rbb_if_inst));
  rbb_checker rbb_checker_inst (.bus_clk(bus_clk),
    .bus_reset_n(bus_reset_n), .addr_hi(rbb_if_inst.addr_o[15:8]),
    .addr_oe_n(rbb_if_inst.addr_oe_n),
    .cpu_data_oe_n(rbb_if_inst.cpu_data_oe_n),
    .ctl_oe_n(rbb_if_inst.ctl_oe_n),
    .memory_cycle_n(rbb_if_inst.memory_cycle_n),
    .io_cycle_n(rbb_if_inst.io_cycle_n), .rd_n(rbb_if_inst.rd_n),
    .wr_n(rbb_if_inst.wr_n), .refresh_cycle_n(rbb_if_inst.refresh_cycle_n),
    .bus_released_n(rbb_if_inst.bus_released_n),
    .bus_takeover_req_n(rbb_if_inst.bus_takeover_req_n),
    .dma_ack_chain_out_n(rbb_if_inst.dma_ack_chain_out_n),
    .halt_n(rbb_if_inst.halt_n), .int_n(rbb_if_inst.int_n),
    .nmi_n(rbb_if_inst.nmi_n), .wait_n(rbb_if_inst.wait_n),
    .page(rbb_if_inst.page), .irq_chain_in(rbb_if_inst.irq_chain_in),
    .irq_chain_out(rbb_if_inst.irq_chain_out));

  // Counts pulses and notes fetch and refresh cycles.
  always @(posedge clk) begin
    if (rsp_valid === 1'h1) rsp_cnt++;
    if (io_valid === 1'h1) io_cnt++;
    if (nmi_seen === 1'h1) nmi_cnt++;
  end
  always @(posedge bus_clk) begin
    if (rbb_if_inst.refresh_cycle_n === 1'h0) saw_refresh_cycle_n = 1'h1;
    if (rbb_if_inst.opcode_fetch_cycle_n === 1'h0) saw_fetch = 1'h1;
  end

  task automatic summarize;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Waits for ready, then holds a request over one edge.
  task automatic issue(input rbb_kind_t k, input logic [15:0] a,
                       input logic [7:0] d);
    int i;
    for (i = 0; i < 400 && req_ready !== 1'h1; i++) @(negedge clk);
    req_kind = k;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'h1;
    @(negedge clk);
    req_valid = 1'h0;
  endtask

  task automatic wait_rsp(input int lim);
    int i;
    for (i = 0; i < lim && rsp_valid !== 1'h1; i++) @(negedge clk);
    check(24'(i < lim), 24'h1);
    rd = rsp_rdata;
    @(negedge clk);
  endtask

  task automatic op(input rbb_kind_t k, input logic [15:0] a,
                    input logic [7:0] d);
    issue(k, a, d);
    wait_rsp(300);
  endtask

  task automatic t_reset;
    check(rbb_if_inst.page, 1'h0);
    check(page_ram, 1'h0);
    check(halted, 1'h0);
    check(rbb_if_inst.memory_cycle_n, 1'h1);
    check(rbb_if_inst.addr, 24'h000000);
  endtask

  task automatic t_memory;
    op(RBB_WRITE, 16'h0010, 8'h5A);
    op(RBB_READ, 16'h0010, 8'h00);
    check(rd, 8'hB5);
    op(RBB_PAGE_RAM, 16'h0000, 8'h00);
    cyc(10);
    check(page_ram, 1'h1);
    op(RBB_WRITE, 16'h0010, 8'h5A);
    op(RBB_READ, 16'h0010, 8'h00);
    check(rd, 8'h5A);
    op(RBB_PAGE_ROM, 16'h0000, 8'h00);
    op(RBB_READ, 16'h0010, 8'h00);
    check(rd, 8'hB5);
    op(RBB_READ, 16'h1234, 8'h00);
    check(rd, 8'h00);
  endtask

  task automatic t_io;
    int c;
    c = io_cnt;
    op(RBB_IO_WRITE, 16'h0040, 8'h3C);
    cyc(20);
    check(24'(io_cnt - c), 24'h1);
    check(io_data, 8'h3C);
    op(RBB_WRITE, 16'hFF40, 8'hC3);
    cyc(20);
    check(24'(io_cnt - c), 24'h2);
    check(io_data, 8'hC3);
    op(RBB_IO_WRITE, 16'h0041, 8'h77);
    cyc(20);
    check(24'(io_cnt - c), 24'h2);
    op(RBB_IO_READ, 16'h0041, 8'h00);
    check(rd, 8'h00);
  endtask

  task automatic t_fetch;
    saw_refresh_cycle_n = 1'h0;
    saw_fetch = 1'h0;
    op(RBB_FETCH, 16'h0020, 8'h00);
    check(rd, 8'h85);
    check(saw_fetch, 1'h1);
    check(saw_refresh_cycle_n, 1'h1);
  endtask

  // Halt left first by a level interrupt, then by an NMI edge.
  task automatic t_halt;
    int c;
    c = rsp_cnt;
    issue(RBB_HALT, 16'h0000, 8'h00);
    cyc(40);
    check(halted, 1'h1);
    check(24'(rsp_cnt - c), 24'h0);
    check(rbb_if_inst.irq_chain_out, 1'h1);
    irq_req = 1'h1;
    wait_rsp(300);
    check(int_pending, 1'h1);
    check(rbb_if_inst.irq_chain_out, 1'h0);
    irq_req = 1'h0;
    cyc(30);
    check(halted, 1'h0);
    check(rbb_if_inst.irq_chain_out, 1'h1);
    rbb_if_inst.irq_chain_in = 1'h0;
    cyc(1);
    check(rbb_if_inst.irq_chain_out, 1'h0);
    rbb_if_inst.irq_chain_in = 1'h1;
    c = nmi_cnt;
    issue(RBB_HALT, 16'h0000, 8'h00);
    cyc(40);
    nmi_req = 1'h1;
    cyc(1);
    nmi_req = 1'h0;
    wait_rsp(300);
    cyc(40);
    check(24'(nmi_cnt - c), 24'h1);
    check(halted, 1'h0);
  endtask

  // A read queued during takeover completes after release.
  task automatic t_takeover;
    int i;
    int c;
    takeover_req = 1'h1;
    for (i = 0; i < 100 && granted !== 1'h1; i++) @(negedge clk);
    check(granted, 1'h1);
    check(released, 1'h1);
    check(rbb_if_inst.addr, 24'h000000);
    check(rbb_if_inst.rd_n, 1'h1);
    c = rsp_cnt;
    issue(RBB_READ, 16'h0011, 8'h00);
    cyc(60);
    check(24'(rsp_cnt - c), 24'h0);
    takeover_req = 1'h0;
    wait_rsp(300);
    check(rd, 8'hB4);
    cyc(20);
    check(granted, 1'h0);
  endtask

  task automatic t_serial;
    logic [3:0] p;
    int         k;
    for (k = 0; k < 2; k++) begin
      p = (k == 0) ? 4'h5 : 4'hA;
      {tx_in, tx2_in, rx_in, rx2_in} = p;
      cyc(20);
      check({tx_out, tx2_out, rx_out, rx2_out}, p);
      check({rbb_if_inst.tx, rbb_if_inst.tx2}, p[3:2]);
    end
    {tx_in, tx2_in, rx_in, rx2_in} = 4'hF;
  endtask

  // Cuts a hung run short.
  initial begin
    #200000;
    miscompares++;
    summarize();
  end

  // Resets both domains, then runs every scenario in turn.
  initial begin
    clk = 1'h0;
    reset = 1'h1;
    bus_reset_n = 1'h0;
    req_valid = 1'h0;
    req_kind = RBB_READ;
    req_addr = 16'h0000;
    req_wdata = 8'h00;
    {tx_in, tx2_in, rx_in, rx2_in} = 4'hF;
    {irq_req, takeover_req, nmi_req} = 3'h0;
    rbb_if_inst.irq_chain_in = 1'h1;
    {miscompares, n_compared, rsp_cnt, io_cnt, nmi_cnt} = '0;
    cyc(3);
    reset = 1'h0;
    cyc(7);
    bus_reset_n = 1'h1;
    cyc(20);
    t_reset();
    t_memory();
    t_io();
    t_fetch();
    t_halt();
    t_takeover();
    t_serial();
    summarize();
  end
endmodule
